// >>> design/asq_params.svh
// Constants of the serial mode sequencer
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH

`define ASQ_CTRL_BITS 4'h8
`define ASQ_POL_BIT_IDX 4'h1
`define ASQ_MODE_BIT_IDX 4'h4
`define ASQ_PORT_BIT_IDX 4'h7
`define ASQ_CLK_SEL_POS 4
`define ASQ_MODE_SHORT 2'h0
`define ASQ_MODE_CAL 2'h1
`define ASQ_MODE_PDN 2'h2
`define ASQ_MODE_LONG 2'h3
`define ASQ_ACQ_END_SHORT 6'h06
`define ASQ_ACQ_EXTRA 6'h08
`define ASQ_CONV_FALL 6'h07
`define ASQ_FRAME_SHORT 6'h18
`define ASQ_FRAME_LONG 6'h20
`define ASQ_RESULT_BITS 6'h10
`define ASQ_RD_LAST 5'h0f
`define ASQ_CAL_CYCLES 80000
`define ASQ_CLK_NS 5
`define ASQ_CONV_NS 6000
`define ASQ_CONV_CYCLES (`ASQ_CONV_NS / `ASQ_CLK_NS)
`define ASQ_SYNC_INIT 5'h0b
`define ASQ_REG_CTRL 2'h0
`define ASQ_REG_STATUS 2'h1
`define ASQ_REG_CFG 2'h2
`define ASQ_CTRL_RST 1'h1

`endif

// >>> design/asq_pkg.sv
// Types of the serial mode sequencer
package asq_pkg;

  typedef enum logic [5:0] {
    ASQ_IDLE = 6'h01,
    ASQ_CTRL = 6'h02,
    ASQ_CONV = 6'h04,
    ASQ_READ = 6'h08,
    ASQ_CAL = 6'h10,
    ASQ_POWERDOWN_PIN_N = 6'h20
  } asq_state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic rst_n;
    logic pdn_n;
  } asq_pins_t;

  typedef struct packed {
    logic calibrated;
    logic unipolar;
    logic clk_int;
    logic acq_long;
    logic pdn_req;
  } asq_cfg_t;

endpackage : asq_pkg

// >>> design/asq_sequencer.sv
// Serial mode sequencer of the sampling converter control path
`timescale 1ns/100ps
`default_nettype none
`include "asq_params.svh"

module asq_sequencer #(
  parameter int CAL_CYCLES = `ASQ_CAL_CYCLES,
  parameter int CONV_CYCLES = `ASQ_CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic rst_pin_n,
  input wire logic powerdown_pin_n,
  input wire logic [13:0] core_code,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic dout,
  output logic done_strobe,
  output logic done_strobe_oe,
  output logic port_out_0,
  output logic port_out_1,
  output logic port_out_2,
  output logic sampling,
  output logic unipolar_mode,
  output logic powered_down,
  output logic cal_defaults
);

  // Synchronised pins
  logic [4:0] pins_s;
  asq_pkg::asq_pins_t pin;

  asq_sync #(
    .WIDTH(5),
    .INIT(`ASQ_SYNC_INIT)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({sclk, cs_n, din, rst_pin_n, powerdown_pin_n}),
    .sync_out(pins_s)
  );

  assign pin = pins_s;

  // State
  asq_pkg::asq_state_t st_q;
  asq_pkg::asq_state_t st_d;
  asq_pkg::asq_cfg_t cfg_q;
  logic sclk_q;
  logic rearm_q;
  logic link_en_q;
  logic acq_q;
  logic strobe_q;
  logic strobe_d;
  logic oe_q;
  logic pd_q;
  logic cal_def_q;
  logic dout_q;
  logic [1:0] mode_q;
  logic [2:0] port_q;
  logic [6:0] shreg_q;
  logic [3:0] bit_cnt_q;
  logic [5:0] fall_cnt_q;
  logic [4:0] rd_cnt_q;
  logic [15:0] shout_q;
  logic [7:0] rdata_q;
  logic cal_done;
  logic conv_done;

  // Serial clock edges, ignored while select is high
  wire cs_low = ~pin.cs_n;
  wire sclk_rise = pin.sclk & ~sclk_q & cs_low;
  wire sclk_fall = ~pin.sclk & sclk_q & cs_low;
  wire hw_rst = ~pin.rst_n;
  wire pdn_pin = ~pin.pdn_n;

  wire in_idle = st_q == asq_pkg::ASQ_IDLE;
  wire in_ctrl = st_q == asq_pkg::ASQ_CTRL;
  wire in_conv = st_q == asq_pkg::ASQ_CONV;
  wire in_read = st_q == asq_pkg::ASQ_READ;
  wire in_cal = st_q == asq_pkg::ASQ_CAL;
  wire in_powerdown_pin_n = st_q == asq_pkg::ASQ_POWERDOWN_PIN_N;

  // Start bit: first high bit while idle or powered down, or after select was pulsed high
  wire start = sclk_rise & pin.din & link_en_q & ~pdn_pin
    & (in_idle | in_powerdown_pin_n | rearm_q);

  // Control bits still arriving
  wire take_bit = sclk_rise & ~start & (in_ctrl | in_conv | in_cal)
    & (bit_cnt_q < `ASQ_CTRL_BITS);
  wire pol_bit = take_bit & (bit_cnt_q == `ASQ_POL_BIT_IDX);
  wire mode_bit = take_bit & (bit_cnt_q == `ASQ_MODE_BIT_IDX);
  wire port_bit = take_bit & (bit_cnt_q == `ASQ_PORT_BIT_IDX);
  wire [1:0] mode_in = {shreg_q[0], pin.din};
  wire new_clk_int = shreg_q[`ASQ_CLK_SEL_POS];

  // Acquisition and frame lengths in serial clocks
  wire [5:0] fall_next = fall_cnt_q + 6'h01;
  wire [5:0] acq_end = cfg_q.acq_long
    ? (`ASQ_ACQ_END_SHORT + `ASQ_ACQ_EXTRA) : `ASQ_ACQ_END_SHORT;
  wire [5:0] frame_len = cfg_q.acq_long ? `ASQ_FRAME_LONG : `ASQ_FRAME_SHORT;
  wire [5:0] read_at = frame_len - `ASQ_RESULT_BITS;
  wire is_cal = mode_q == `ASQ_MODE_CAL;

  wire acq_stop = sclk_fall & acq_q & (in_ctrl | in_conv) & ~is_cal
    & (fall_next == acq_end);
  wire conv_go = sclk_fall & in_ctrl & (fall_next == `ASQ_CONV_FALL);
  wire ext_ready = sclk_fall & in_conv & ~cfg_q.clk_int & (fall_next == read_at);
  wire load_result = in_conv & (cfg_q.clk_int ? conv_done : ext_ready);
  wire rd_done = in_read & sclk_fall & (rd_cnt_q == `ASQ_RD_LAST);
  wire cal_abort = in_cal & (pdn_pin | start);

  // Result format
  wire [13:0] code_fmt = cfg_q.unipolar
    ? core_code : {~core_code[13], core_code[12:0]};

  // Calibration and internal conversion timers
  asq_tick_timer #(
    .LIMIT(CAL_CYCLES)
  ) u_cal_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(~in_cal | cal_abort),
    .tick(cfg_q.clk_int | sclk_fall),
    .done(cal_done)
  );

  asq_tick_timer #(
    .LIMIT(CONV_CYCLES)
  ) u_conv_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(~in_conv | ~cfg_q.clk_int),
    .tick(1'b1),
    .done(conv_done)
  );

  // Register read mux
  wire [7:0] status_word = {2'h0, st_q};
  wire [7:0] cfg_word = {cfg_q, port_q};
  wire [7:0] ctrl_word = {7'h00, link_en_q};
  wire [7:0] rd_mux = (reg_addr == `ASQ_REG_CTRL) ? ctrl_word
    : (reg_addr == `ASQ_REG_STATUS) ? status_word
    : (reg_addr == `ASQ_REG_CFG) ? cfg_word : 8'h00;

  // Next state
  always_comb begin
    st_d = st_q;
    if (pdn_pin) begin
      st_d = asq_pkg::ASQ_POWERDOWN_PIN_N;
    end else if (start) begin
      st_d = asq_pkg::ASQ_CTRL;
    end else begin
      case (st_q)
        asq_pkg::ASQ_CTRL: begin
          if (conv_go) begin
            st_d = is_cal ? asq_pkg::ASQ_CAL : asq_pkg::ASQ_CONV;
          end
        end
        asq_pkg::ASQ_CONV: begin
          if (load_result) begin
            st_d = asq_pkg::ASQ_READ;
          end
        end
        asq_pkg::ASQ_READ: begin
          if (rd_done) begin
            st_d = cfg_q.pdn_req ? asq_pkg::ASQ_POWERDOWN_PIN_N : asq_pkg::ASQ_IDLE;
          end
        end
        asq_pkg::ASQ_CAL: begin
          if (cal_done) begin
            st_d = asq_pkg::ASQ_IDLE;
          end
        end
        asq_pkg::ASQ_POWERDOWN_PIN_N: begin
          if (!cfg_q.pdn_req) begin
            st_d = asq_pkg::ASQ_IDLE;
          end
        end
        asq_pkg::ASQ_IDLE: begin
          st_d = asq_pkg::ASQ_IDLE;
        end
        default: begin
          st_d = asq_pkg::ASQ_IDLE;
        end
      endcase
    end
  end

  // Strobe level
  always_comb begin
    strobe_d = strobe_q;
    if (cal_abort || (in_cal && cal_done)) begin
      strobe_d = cfg_q.clk_int;
    end else if (conv_go) begin
      strobe_d = is_cal & ~new_clk_int;
    end else if (load_result) begin
      strobe_d = 1'b1;
    end else if (in_read && sclk_fall && !cfg_q.clk_int) begin
      strobe_d = 1'b0;
    end
  end

  // Main sequencing registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= asq_pkg::ASQ_IDLE;
      cfg_q <= '{calibrated: 1'b0, unipolar: 1'b0, clk_int: 1'b1,
                 acq_long: 1'b0, pdn_req: 1'b0};
      port_q <= 3'h0;
      mode_q <= `ASQ_MODE_SHORT;
      strobe_q <= 1'b1;
      acq_q <= 1'b0;
    end else if (hw_rst) begin
      st_q <= asq_pkg::ASQ_IDLE;
      cfg_q <= '{calibrated: 1'b0, unipolar: 1'b0, clk_int: 1'b1,
                 acq_long: 1'b0, pdn_req: 1'b0};
      port_q <= 3'h0;
      mode_q <= `ASQ_MODE_SHORT;
      strobe_q <= 1'b1;
      acq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      strobe_q <= strobe_d;
      if (start) begin
        acq_q <= 1'b1;
        cfg_q.unipolar <= 1'b0;
        cfg_q.pdn_req <= 1'b0;
        mode_q <= `ASQ_MODE_SHORT;
      end else begin
        if (pol_bit) begin
          cfg_q.unipolar <= pin.din;
        end
        if (mode_bit) begin
          mode_q <= mode_in;
          cfg_q.pdn_req <= mode_in == `ASQ_MODE_PDN;
          if (mode_in != `ASQ_MODE_PDN && mode_in != `ASQ_MODE_CAL) begin
            cfg_q.acq_long <= mode_in == `ASQ_MODE_LONG;
          end
        end
        if (port_bit) begin
          port_q <= {shreg_q[1:0], pin.din};
        end
        if (conv_go) begin
          cfg_q.clk_int <= new_clk_int;
        end
        if (acq_stop || conv_go && is_cal || pdn_pin) begin
          acq_q <= 1'b0;
        end
        if (in_cal && cal_done) begin
          cfg_q.calibrated <= 1'b1;
        end
      end
    end
  end

  // Serial shift, counters and readout
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      rearm_q <= 1'b0;
      shreg_q <= 7'h00;
      bit_cnt_q <= 4'h0;
      fall_cnt_q <= 6'h00;
      rd_cnt_q <= 5'h00;
      shout_q <= 16'h0000;
      dout_q <= 1'b0;
    end else begin
      sclk_q <= pin.sclk;
      if (start) begin
        rearm_q <= 1'b0;
      end else if (pin.cs_n) begin
        rearm_q <= 1'b1;
      end
      if (start) begin
        shreg_q <= 7'h01;
        bit_cnt_q <= 4'h1;
        fall_cnt_q <= 6'h00;
      end else begin
        if (take_bit) begin
          shreg_q <= {shreg_q[5:0], pin.din};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (sclk_fall && (in_ctrl || in_conv)) begin
          fall_cnt_q <= fall_next;
        end
      end
      if (load_result) begin
        shout_q <= {code_fmt, 2'h0};
        dout_q <= code_fmt[13];
        rd_cnt_q <= 5'h00;
      end else if (in_read && sclk_fall) begin
        shout_q <= {shout_q[14:0], 1'b0};
        dout_q <= shout_q[14];
        rd_cnt_q <= rd_cnt_q + 5'h01;
      end
    end
  end

  // Register port and registered pin outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_en_q <= `ASQ_CTRL_RST;
      rdata_q <= 8'h00;
      oe_q <= 1'b1;
      pd_q <= 1'b0;
      cal_def_q <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == `ASQ_REG_CTRL) begin
        link_en_q <= reg_wdata[0];
      end
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      oe_q <= cfg_q.clk_int | cs_low;
      pd_q <= st_d == asq_pkg::ASQ_POWERDOWN_PIN_N;
      cal_def_q <= hw_rst;
    end
  end

  assign reg_rdata = rdata_q;
  assign dout = dout_q;
  assign done_strobe = strobe_q;
  assign done_strobe_oe = oe_q;
  assign port_out_0 = port_q[0];
  assign port_out_1 = port_q[1];
  assign port_out_2 = port_q[2];
  assign sampling = acq_q;
  assign unipolar_mode = cfg_q.unipolar;
  assign powered_down = pd_q;
  assign cal_defaults = cal_def_q;

endmodule : asq_sequencer

`default_nettype wire

// >>> design/asq_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module asq_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : asq_sync

`default_nettype wire

// >>> design/asq_tick_timer.sv
// Tick counter that flags the last of LIMIT ticks
`timescale 1ns/100ps
`default_nettype none

module asq_tick_timer #(
  parameter int LIMIT = 80000,
  parameter int WIDTH = $clog2(LIMIT + 1)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  output logic done
);

  logic [WIDTH-1:0] cnt_q;

  assign done = tick & ~clear & (cnt_q == WIDTH'(LIMIT - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clear || done) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + WIDTH'(1);
    end
  end

endmodule : asq_tick_timer

`default_nettype wire

// >>> tb/asq_host_model.sv
// Serial host model driving the control link
`timescale 1ns/100ps
`default_nettype none
module asq_host_model (
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout,
  input wire logic done_strobe,
  input wire logic sampling
);
  logic [15:0] rx;
  logic [63:0] stb;
  int samp_end;
  realtime t7;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Link clock runs only inside a frame; data changes on falling edges
  task automatic frame(input logic [7:0] ctl, input int n, input int ld);
    logic [63:0] bits;
    bits = {ctl, 56'h0};
    rx = '0;
    stb = '0;
    samp_end = 0;
    #103 cs_n = 1'b0;
    din = bits[63];
    #32;
    for (int i = 1; i <= n; i++) begin
      sclk = 1'b1;
      #32 sclk = 1'b0;
      bits = bits << 1;
      din = bits[63];
      if (i == 7) t7 = $realtime;
      #30 stb[i] = done_strobe;
      if (!sampling && samp_end == 0) samp_end = i;
      if (i >= ld && i < ld + 16) rx = {rx[14:0], dout};
      #2;
    end
    cs_n = 1'b1;
    if (ctl[6] && !ctl[5] && ctl[4:3] == 2'h0) #6500;
  endtask : frame
endmodule : asq_host_model
`default_nettype wire

// >>> tb/asq_monitor.sv
// Port checker of the serial mode sequencer
`timescale 1ns/100ps
`default_nettype none
module asq_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic rst_pin_n,
  input wire logic powerdown_pin_n,
  input wire logic done_strobe,
  input wire logic port_out_0,
  input wire logic port_out_1,
  input wire logic port_out_2,
  input wire logic sampling,
  input wire logic unipolar_mode,
  input wire logic powered_down,
  input wire logic cal_defaults
);
  wire logic [2:0] ports = {port_out_2, port_out_1, port_out_0};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_pin_rst;
    !rst_pin_n [*6] |-> cal_defaults && ports == 3'h0 && !unipolar_mode && done_strobe;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset");
  property p_pdn_pin;
    (!powerdown_pin_n && rst_pin_n) [*7] |-> powered_down;
  endproperty
  a_pdn_pin: assert property (p_pdn_pin) else $error("shutdown pin");
  property p_pdn_hold;
    powered_down && $past(powered_down) && rst_pin_n |-> $stable(ports);
  endproperty
  a_pdn_hold: assert property (p_pdn_hold) else $error("ports moved");
  property p_start;
    $rose(sampling) |-> $past(sclk) && $past(din) && !cs_n;
  endproperty
  a_start: assert property (p_start) else $error("start bit");
  property p_no_start;
    cs_n [*6] |-> !$rose(sampling);
  endproperty
  a_no_start: assert property (p_no_start) else $error("start deselected");
  property p_acq_end;
    $fell(sampling) && rst_pin_n && powerdown_pin_n |-> !$past(sclk);
  endproperty
  a_acq_end: assert property (p_acq_end) else $error("acquisition end");
  property p_uni;
    $changed(unipolar_mode) && rst_pin_n |-> $past(sclk) && !cs_n;
  endproperty
  a_uni: assert property (p_uni) else $error("polarity change");
  property p_port_upd;
    $changed(ports) && rst_pin_n |-> $past(sclk) && !cs_n;
  endproperty
  a_port_upd: assert property (p_port_upd) else $error("port update");
endmodule : asq_monitor
bind asq_sequencer asq_monitor i_asq_monitor (
  .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
  .rst_pin_n(rst_pin_n), .powerdown_pin_n(powerdown_pin_n), .done_strobe(done_strobe),
  .port_out_0(port_out_0), .port_out_1(port_out_1), .port_out_2(port_out_2),
  .sampling(sampling), .unipolar_mode(unipolar_mode), .powered_down(powered_down),
  .cal_defaults(cal_defaults)
);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the serial mode sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys, rst_n, rst_pin_n, powerdown_pin_n, reg_wr, reg_rd, pol, lng;
  logic sclk, cs_n, din, dout, done_strobe, sampling, unipolar_mode, powered_down;
  logic cal_defaults, port_out_0, port_out_1, port_out_2, strobe_oe;
  logic [13:0] core_code;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, ctl;
  int bad_count, comparisons, seed, n;
  realtime t;
  wire logic [2:0] ports = {port_out_2, port_out_1, port_out_0};
  asq_sequencer #(.CAL_CYCLES(40), .CONV_CYCLES(20)) i_asq_sequencer (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .rst_pin_n(rst_pin_n), .powerdown_pin_n(powerdown_pin_n), .core_code(core_code),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dout(dout), .done_strobe(done_strobe), .done_strobe_oe(strobe_oe),
    .port_out_0(port_out_0), .port_out_1(port_out_1), .port_out_2(port_out_2),
    .sampling(sampling), .unipolar_mode(unipolar_mode), .powered_down(powered_down),
    .cal_defaults(cal_defaults));
  asq_host_model i_asq_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .done_strobe(done_strobe), .sampling(sampling));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic wait_strobe;
    n = 0;
    while (done_strobe !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, done_strobe, 1'b1);
      end_sim();
    end
  endtask : wait_strobe
  task automatic reg_rw(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_rw
  task automatic pin_abort(input logic which, input logic [15:0] want);
    i_asq_host_model.frame(8'haf, 8, 99);
    @(posedge clk_sys);
    if (which) rst_pin_n <= 1'b0;
    else powerdown_pin_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk({11'h0, done_strobe, which ? cal_defaults : powered_down, ports}, want);
    rst_pin_n <= 1'b1;
    powerdown_pin_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : pin_abort
  initial begin
    seed = 95;
    bad_count = 0;
    comparisons = 0;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, core_code} = '0;
    {rst_pin_n, powerdown_pin_n} = 2'h3;
    repeat (2) @(posedge clk_sys);
    chk({9'h0, ports, unipolar_mode, powered_down, done_strobe, cal_defaults}, 16'h0003);
    rst_n <= 1'b1;
    reg_rw(1'b0, 2'h1, 8'h00);
    chk({8'h0, rd}, 16'h0001);
    reg_rw(1'b1, 2'h3, 8'hff);
    reg_rw(1'b0, 2'h3, 8'h00);
    chk({8'h0, rd}, 16'h0000);
    $display("Test registers done");
    i_asq_host_model.frame(8'haf, 8, 99);
    chk({12'h0, i_asq_host_model.stb[8], ports}, 16'h0007);
    wait_strobe();
    t = $realtime - i_asq_host_model.t7;
    chk({15'h0, t >= 200.0 && t <= 245.0}, 16'h0001);
    reg_rw(1'b0, 2'h2, 8'h00);
    chk({15'h0, rd[7]}, 16'h0001);
    pin_abort(1'b1, 16'h0018);
    pin_abort(1'b0, 16'h001f);
    i_asq_host_model.frame(8'h88, 60, 99);
    chk({13'h0, i_asq_host_model.stb[8], i_asq_host_model.stb[45],
      i_asq_host_model.stb[50]}, 16'h0006);
    $display("Test calibration done");
    reg_rw(1'b1, 2'h0, 8'h00);
    i_asq_host_model.frame(8'h87, 8, 99);
    chk({13'h0, ports}, 16'h0000);
    reg_rw(1'b1, 2'h0, 8'h01);
    for (int k = 0; k < 8; k++) begin
      pol = 1'($random(seed));
      lng = (k == 7) ? 1'b1 : 1'($random(seed));
      @(posedge clk_sys);
      core_code <= (k == 0) ? 14'h2000 : 14'($random(seed));
      ctl = {1'b1, pol, 1'b0, lng, lng, 3'($random(seed))};
      i_asq_host_model.frame(ctl, lng ? 32 : 24, lng ? 16 : 8);
      chk(i_asq_host_model.rx, {pol ? core_code : core_code ^ 14'h2000, 2'h0});
      chk(16'(i_asq_host_model.samp_end), lng ? 16'h000e : 16'h0006);
      chk({12'h0, unipolar_mode, ports}, {12'h0, pol, ctl[2:0]});
    end
    i_asq_host_model.frame(8'h95, 32, 16);
    chk(16'(i_asq_host_model.samp_end), 16'h000e);
    repeat (4) @(posedge clk_sys);
    chk({11'h0, strobe_oe, powered_down, ports}, 16'h000d);
    i_asq_host_model.frame(8'h80, 24, 8);
    chk({12'h0, powered_down, ports}, 16'h0000);
    // Internal clock conversion: strobe low, then high with result MSB on dout
    @(posedge clk_sys);
    core_code <= 14'h0abc;
    i_asq_host_model.frame(8'ha0, 8, 99);
    wait_strobe();
    chk({13'h0, strobe_oe, i_asq_host_model.stb[8], dout}, 16'h0005);
    $display("Test conversions done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
